/* File: ddr_bank_pkg.sv */
// Shared constants and types for the bank command legality design
package ddr_bank_pkg;

    // Geometry
    localparam int NUM_BANKS  = 4;
    localparam int BANK_W     = 2;
    localparam int ADDR_W     = 13;
    localparam int AP_BIT     = 10;   // Auto precharge / all-bank select bit

    // Clock and timing (ns); cycle counts derived at 20 MHz
    localparam int CLK_PERIOD_NS          = 50;
    localparam int PRECHARGE_PERIOD_NS    = 20;
    localparam int ACT_TO_COL_DELAY_NS    = 20;
    localparam int REFRESH_CYCLE_TIME_NS  = 75;
    localparam int MODE_SET_DELAY_NS      = 15;
    localparam int WRITE_TO_READ_DELAY_NS = 10;

    // Least times round up, never below one cycle
    function automatic int cyc(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction : cyc

    localparam int PRECHARGE_PERIOD_CYC    = cyc(PRECHARGE_PERIOD_NS);
    localparam int ACT_TO_COL_DELAY_CYC    = cyc(ACT_TO_COL_DELAY_NS);
    localparam int REFRESH_CYCLE_TIME_CYC  = cyc(REFRESH_CYCLE_TIME_NS);
    localparam int MODE_SET_DELAY_CYC      = cyc(MODE_SET_DELAY_NS);
    localparam int WRITE_TO_READ_DELAY_CYC = cyc(WRITE_TO_READ_DELAY_NS);

    // Fixed burst length 4, read latency 3 (whole clocks)
    localparam int BURST_LENGTH  = 4;
    localparam int BURST_CYC     = BURST_LENGTH / 2;
    localparam int READ_LATENCY  = 3;

    // Other-bank gaps after an auto precharge access
    localparam int GAP_WAP_RD = 1 + BURST_CYC + WRITE_TO_READ_DELAY_CYC;
    localparam int GAP_WAP_WR = BURST_CYC;
    localparam int GAP_RAP_RD = BURST_CYC;
    localparam int GAP_RAP_WR = READ_LATENCY + BURST_CYC;
    localparam int GAP_AP_PA  = 1;

    localparam int CNT_W = 4;

    // Command codes {cs_n, ras_n, cas_n, we_n}
    typedef enum logic [3:0] {
        CMD_DESELECT  = 4'h8,
        CMD_NOP       = 4'h7,
        CMD_ACTIVATE  = 4'h3,
        CMD_READ      = 4'h5,
        CMD_WRITE     = 4'h4,
        CMD_BURST_END = 4'h6,
        CMD_PRECHARGE = 4'h2,
        CMD_REFRESH   = 4'h1,
        CMD_MODE_SET  = 4'h0
    } cmd_t;

    // Per-bank states, Gray along idle->activating->active->burst
    typedef enum logic [2:0] {
        BK_IDLE       = 3'h0,
        BK_ACTIVATING = 3'h1,
        BK_ACTIVE     = 3'h3,
        BK_READ       = 3'h2,
        BK_WRITE      = 3'h6,
        BK_READ_AP    = 3'h7,
        BK_WRITE_AP   = 3'h5,
        BK_PRECHARGE  = 3'h4
    } bank_state_t;

endpackage : ddr_bank_pkg

/* File: ddr_cmd_if.sv */
// Command link between the memory controller and the device bank logic
`timescale 1ns/1ps
interface ddr_cmd_if;
    logic                             cke;
    logic                             cs_n;
    logic                             ras_n;
    logic                             cas_n;
    logic                             we_n;
    logic [ddr_bank_pkg::BANK_W-1:0]  bank;
    logic [ddr_bank_pkg::ADDR_W-1:0]  addr;

    modport ctrl (output cke, cs_n, ras_n, cas_n, we_n, bank, addr);
    modport dev  (input  cke, cs_n, ras_n, cas_n, we_n, bank, addr);
endinterface : ddr_cmd_if

/* File: ddr_bank_device.sv */
// Device end: per-bank state tracking and command acceptance
// Summary of operation
// - Precharge closes the open row in bank.
// - Read restarts burst; precharge truncates read burst.
// - Burst terminate stops most recent read burst.
// - Write restarts burst; precharge truncates; masked read.
// - Commands count only with clock enable high twice.
// - Idle after precharge period; active after activate delay.
// - Burst state lasts until completion or termination.
// - Never interrupt precharging, activating or auto-precharge bank.
// - Refresh, mode set, precharge-all block all commands.
// - Refresh and mode set only when all idle.
// - Burst terminate never aimed at another bank.
// - Every precharged bank must be in valid state.
// - Unlisted state and command combinations are illegal.
// - Reads and writes may carry auto precharge either way.
// - Other banks act per own state; no write during read.
// - Auto precharge access permits other-bank commands.
// - Write after read auto precharge waits for data.
// - Gaps after write auto precharge to other banks.
// - Gaps after read auto precharge to other banks.
// - Address bit ten selects auto precharge per access.
// - Address bit ten high precharges all banks.
// - Deselect and no-operation continue current work.
`timescale 1ns/1ps
module ddr_bank_device (
    input  wire logic                             i_mclk,
    input  wire logic                             i_rst,
    ddr_cmd_if.dev                                link,
    output logic [3*ddr_bank_pkg::NUM_BANKS-1:0]  o_bank_state,
    output logic                                  o_all_idle,
    output logic                                  o_busy,
    output logic                                  o_cmd_error
);
    localparam int NB = ddr_bank_pkg::NUM_BANKS;
    localparam int CW = ddr_bank_pkg::CNT_W;

    // Two-flop synchronisers on every link input (pins from outside)
    logic [19:0] sync1_q;
    logic [19:0] sync2_q;
    logic        cke_prev_q;
    always_ff @(posedge i_mclk) begin
        sync1_q <= {link.cke, link.cs_n, link.ras_n, link.cas_n, link.we_n,
                    link.bank, link.addr};
        sync2_q <= sync1_q;
        cke_prev_q <= i_rst ? 1'b0 : sync2_q[19];
    end

    wire       cke_now  = sync2_q[19];
    wire [3:0] cmd_raw  = sync2_q[18:15];
    wire [1:0] cmd_bank = sync2_q[14:13];
    wire       ap_bit   = sync2_q[ddr_bank_pkg::AP_BIT];
    wire       cmd_ok   = cke_now & cke_prev_q;
    // Deselect ignores the strobes; it behaves as a no-operation
    wire [3:0] cmd      = !cmd_ok ? 4'(ddr_bank_pkg::CMD_NOP) :
                          cmd_raw[3] ? 4'(ddr_bank_pkg::CMD_NOP) :
                          cmd_raw;

    wire is_act = (cmd == 4'(ddr_bank_pkg::CMD_ACTIVATE));
    wire is_rd  = (cmd == 4'(ddr_bank_pkg::CMD_READ));
    wire is_wr  = (cmd == 4'(ddr_bank_pkg::CMD_WRITE));
    wire is_bst = (cmd == 4'(ddr_bank_pkg::CMD_BURST_END));
    wire is_pre = (cmd == 4'(ddr_bank_pkg::CMD_PRECHARGE));
    wire is_ref = (cmd == 4'(ddr_bank_pkg::CMD_REFRESH));
    wire is_mrs = (cmd == 4'(ddr_bank_pkg::CMD_MODE_SET));

    // Device-wide lockout for refresh, mode set and precharge-all
    logic [CW-1:0] glob_cnt_q;
    logic [1:0]    last_rd_bank_q;
    logic          rd_seen_q;
    logic          rd_busy;                 // Any bank in a plain read burst (BK_READ)
    logic [NB-1:0] idle_v;
    logic [NB-1:0] rd_v;
    logic [NB-1:0] err_v;

    wire glob_busy = (glob_cnt_q != '0);
    wire all_idle  = &idle_v;
    wire pre_all   = is_pre & ap_bit;
    assign rd_busy = |rd_v;

    // Device-wide errors: lockout violated, refresh/mode set with a bank not idle, burst terminate with no read burst
    wire glob_err = (glob_busy & (cmd != 4'(ddr_bank_pkg::CMD_NOP)))
                  | ((is_ref | is_mrs) & ~all_idle)
                  | (is_bst & ~(rd_seen_q & rd_v[last_rd_bank_q]));

    // Global counter loads on refresh, mode set or precharge-all
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            glob_cnt_q <= '0;
        end else if (!glob_busy && is_ref && all_idle) begin
            glob_cnt_q <= CW'(ddr_bank_pkg::REFRESH_CYCLE_TIME_CYC);
        end else if (!glob_busy && is_mrs && all_idle) begin
            glob_cnt_q <= CW'(ddr_bank_pkg::MODE_SET_DELAY_CYC);
        end else if (!glob_busy && pre_all) begin
            glob_cnt_q <= CW'(ddr_bank_pkg::PRECHARGE_PERIOD_CYC);
        end else if (glob_busy) begin
            glob_cnt_q <= glob_cnt_q - 1'b1;
        end
    end

    // Remember the bank of the most recent read for burst terminate
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            last_rd_bank_q <= 2'h0;
            rd_seen_q      <= 1'b0;
        end else if (is_rd && !glob_busy) begin
            last_rd_bank_q <= cmd_bank;
            rd_seen_q      <= 1'b1;
        end
    end

    // One state machine and counter per bank
    genvar b;
    generate
        for (b = 0; b < NB; b++) begin : g_bank
            ddr_bank_pkg::bank_state_t st_q;
            ddr_bank_pkg::bank_state_t st_d;
            logic [CW-1:0] cnt_q;
            logic [CW-1:0] cnt_d;
            logic          err;
            wire hit  = (cmd_bank == 2'(b)) & ~glob_busy;
            wire done = (cnt_q <= CW'(1));
            wire bst  = is_bst & rd_seen_q & (last_rd_bank_q == 2'(b));

            assign idle_v[b] = (st_q == ddr_bank_pkg::BK_IDLE);
            assign rd_v[b]   = (st_q == ddr_bank_pkg::BK_READ);
            assign err_v[b]  = err;

            // Next state and legality for this bank
            always_comb begin
                st_d  = st_q;
                cnt_d = (cnt_q != '0) ? cnt_q - 1'b1 : cnt_q;
                err   = 1'b0;
                if (pre_all && !glob_busy) begin
                    // Precharge-all leaves every bank idle after the period
                    err   = ~(idle_v[b] | (st_q == ddr_bank_pkg::BK_ACTIVE) |
                              rd_v[b] | (st_q == ddr_bank_pkg::BK_WRITE));
                    st_d  = ddr_bank_pkg::BK_PRECHARGE;
                    cnt_d = CW'(ddr_bank_pkg::PRECHARGE_PERIOD_CYC);
                end else begin
                    unique case (st_q)
                        ddr_bank_pkg::BK_IDLE: begin
                            if (hit && is_act) begin
                                st_d  = ddr_bank_pkg::BK_ACTIVATING;
                                cnt_d = CW'(ddr_bank_pkg::ACT_TO_COL_DELAY_CYC);
                            end else if (hit && (is_rd || is_wr)) begin
                                err = 1'b1;
                            end
                        end
                        ddr_bank_pkg::BK_ACTIVATING,
                        ddr_bank_pkg::BK_PRECHARGE,
                        ddr_bank_pkg::BK_READ_AP,
                        ddr_bank_pkg::BK_WRITE_AP: begin
                            // Uninterruptible: same-bank commands are errors
                            err = hit & (is_act | is_rd | is_wr | is_pre);
                            if (done) begin
                                st_d = (st_q == ddr_bank_pkg::BK_ACTIVATING) ?
                                       ddr_bank_pkg::BK_ACTIVE :
                                       ddr_bank_pkg::BK_IDLE;
                            end else if (done == 1'b0 && cnt_q == '0) begin
                                st_d = ddr_bank_pkg::BK_IDLE;
                            end
                        end
                        default: begin
                            // Active, read and write bursts
                            if (hit && is_pre) begin
                                st_d  = ddr_bank_pkg::BK_PRECHARGE;
                                cnt_d = CW'(ddr_bank_pkg::PRECHARGE_PERIOD_CYC);
                            end else if (hit && (is_rd || is_wr)) begin
                                // New burst restarts; A10 picks auto precharge
                                err = is_wr & rd_busy & ~rd_v[b];
                                if (ap_bit) begin
                                    st_d  = is_rd ? ddr_bank_pkg::BK_READ_AP :
                                                    ddr_bank_pkg::BK_WRITE_AP;
                                    cnt_d = CW'(ddr_bank_pkg::BURST_CYC +
                                        ddr_bank_pkg::PRECHARGE_PERIOD_CYC);
                                end else begin
                                    st_d  = is_rd ? ddr_bank_pkg::BK_READ :
                                                    ddr_bank_pkg::BK_WRITE;
                                    cnt_d = CW'(ddr_bank_pkg::BURST_CYC);
                                end
                            end else if (bst && rd_v[b]) begin
                                st_d = ddr_bank_pkg::BK_ACTIVE;
                            end else if (st_q != ddr_bank_pkg::BK_ACTIVE &&
                                         done) begin
                                st_d = ddr_bank_pkg::BK_ACTIVE;
                            end else if (hit && is_act) begin
                                err = 1'b1;
                            end
                        end
                    endcase
                    // No write while any plain read burst runs
                    if (hit && is_wr && rd_busy) begin
                        err = 1'b1;
                    end
                end
            end

            always_ff @(posedge i_mclk) begin
                if (i_rst) begin
                    st_q  <= ddr_bank_pkg::BK_IDLE;
                    cnt_q <= '0;
                end else begin
                    st_q  <= st_d;
                    cnt_q <= cnt_d;
                end
            end
        end
    endgenerate

    // Registered status; error is a one-cycle pulse per bad command
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            o_bank_state <= '0;
            o_all_idle   <= 1'b1;
            o_busy       <= 1'b0;
            o_cmd_error  <= 1'b0;
        end else begin
            o_bank_state <= {g_bank[3].st_q, g_bank[2].st_q,
                             g_bank[1].st_q, g_bank[0].st_q};
            o_all_idle   <= all_idle & ~glob_busy;
            o_busy       <= glob_busy;
            o_cmd_error  <= glob_err | (|err_v);
        end
    end
endmodule : ddr_bank_device

/* File: ddr_bank_ctrl.sv */
// Controller end: issues user commands only when the bank rules allow
`timescale 1ns/1ps
module ddr_bank_ctrl (
    input  wire logic                             i_mclk,
    input  wire logic                             i_rst,
    ddr_cmd_if.ctrl                               link,
    input  wire logic                             i_req,
    input  wire logic [3:0]                       i_cmd,
    input  wire logic [ddr_bank_pkg::BANK_W-1:0]  i_bank,
    input  wire logic [ddr_bank_pkg::ADDR_W-1:0]  i_addr,
    output logic                                  o_ack
);
    localparam int NB = ddr_bank_pkg::NUM_BANKS;
    localparam int CW = ddr_bank_pkg::CNT_W;

    logic [CW-1:0] bank_cnt_q [NB];   // Same-bank busy time
    logic [NB-1:0] open_q;            // Row open and usable
    logic [NB-1:0] rd_q;              // Plain read burst in flight
    logic [CW-1:0] glob_cnt_q;
    logic [CW-1:0] rd_gap_q;          // Other-bank read spacing
    logic [CW-1:0] wr_gap_q;          // Other-bank write spacing
    logic [CW-1:0] pa_gap_q;          // Other-bank precharge/activate
    logic [CW-1:0] rd_left_q;         // Plain read burst cycles left
    logic          cke_q;
    logic [3:0]    cmd_q;
    logic [1:0]    bank_q;
    logic [ddr_bank_pkg::ADDR_W-1:0] addr_q;

    wire is_act = (i_cmd == 4'(ddr_bank_pkg::CMD_ACTIVATE));
    wire is_rd  = (i_cmd == 4'(ddr_bank_pkg::CMD_READ));
    wire is_wr  = (i_cmd == 4'(ddr_bank_pkg::CMD_WRITE));
    wire is_bst = (i_cmd == 4'(ddr_bank_pkg::CMD_BURST_END));
    wire is_pre = (i_cmd == 4'(ddr_bank_pkg::CMD_PRECHARGE));
    wire is_ref = (i_cmd == 4'(ddr_bank_pkg::CMD_REFRESH));
    wire is_mrs = (i_cmd == 4'(ddr_bank_pkg::CMD_MODE_SET));
    wire ap     = i_addr[ddr_bank_pkg::AP_BIT];

    logic [NB-1:0] free_v;
    genvar b;
    generate
        for (b = 0; b < NB; b++) begin : g_free
            assign free_v[b] = (bank_cnt_q[b] == '0);
        end
    endgenerate
    wire all_idle = (&free_v) & ~(|open_q);
    wire quiet    = (glob_cnt_q == '0) & cke_q;
    wire tgt_free = free_v[i_bank];

    // Legality of the requested command against tracked state
    wire legal =
        quiet & (
        (is_act & tgt_free & ~open_q[i_bank] & (pa_gap_q == '0)) |
        (is_rd  & tgt_free & open_q[i_bank] & (rd_gap_q == '0)) |
        (is_wr  & tgt_free & open_q[i_bank] & (wr_gap_q == '0)
                & ~(|rd_q)) |
        (is_bst & rd_q[i_bank]) |
        (is_pre & (ap ? (&free_v) : tgt_free)
                & (pa_gap_q == '0)) |
        ((is_ref | is_mrs) & all_idle));
    wire take = i_req & legal;

    // Spacing after auto precharge accesses, per the gap table
    function automatic logic [CW-1:0] dec(input logic [CW-1:0] v);
        return (v != '0) ? v - 1'b1 : v;
    endfunction : dec

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            glob_cnt_q <= '0;
            rd_gap_q   <= '0;
            wr_gap_q   <= '0;
            pa_gap_q   <= '0;
            rd_left_q  <= '0;
            open_q     <= '0;
            rd_q       <= '0;
            cke_q      <= 1'b0;
            o_ack      <= 1'b0;
            for (int i = 0; i < NB; i++) begin
                bank_cnt_q[i] <= '0;
            end
        end else begin
            cke_q      <= 1'b1;
            o_ack      <= take;
            glob_cnt_q <= dec(glob_cnt_q);
            rd_gap_q   <= dec(rd_gap_q);
            wr_gap_q   <= dec(wr_gap_q);
            pa_gap_q   <= dec(pa_gap_q);
            rd_left_q  <= dec(rd_left_q);
            // A terminate after the burst ends would hit an active bank
            if (rd_left_q == CW'(1)) begin
                rd_q <= '0;
            end
            for (int i = 0; i < NB; i++) begin
                bank_cnt_q[i] <= dec(bank_cnt_q[i]);
            end
            if (take) begin
                if (is_act) begin
                    bank_cnt_q[i_bank] <=
                        CW'(ddr_bank_pkg::ACT_TO_COL_DELAY_CYC);
                    open_q[i_bank] <= 1'b1;
                end
                if ((is_rd || is_wr) && ap) begin
                    bank_cnt_q[i_bank] <= CW'(ddr_bank_pkg::BURST_CYC +
                                     ddr_bank_pkg::PRECHARGE_PERIOD_CYC);
                    open_q[i_bank] <= 1'b0;
                    rd_gap_q <= is_rd ? CW'(ddr_bank_pkg::GAP_RAP_RD) :
                                        CW'(ddr_bank_pkg::GAP_WAP_RD);
                    wr_gap_q <= is_rd ? CW'(ddr_bank_pkg::GAP_RAP_WR) :
                                        CW'(ddr_bank_pkg::GAP_WAP_WR);
                    pa_gap_q <= CW'(ddr_bank_pkg::GAP_AP_PA);
                end else if (is_rd) begin
                    rd_q[i_bank] <= 1'b1;
                    rd_left_q <= CW'(ddr_bank_pkg::BURST_CYC);
                    wr_gap_q <= CW'(ddr_bank_pkg::GAP_RAP_WR);
                end else if (is_wr) begin
                    rd_gap_q <= CW'(ddr_bank_pkg::GAP_WAP_RD);
                end
                if (is_bst) begin
                    rd_q <= '0;
                end
                if (is_pre && ap) begin
                    glob_cnt_q <= CW'(ddr_bank_pkg::PRECHARGE_PERIOD_CYC);
                    open_q     <= '0;
                    rd_q       <= '0;
                end else if (is_pre) begin
                    bank_cnt_q[i_bank] <=
                        CW'(ddr_bank_pkg::PRECHARGE_PERIOD_CYC);
                    open_q[i_bank] <= 1'b0;
                    rd_q[i_bank]   <= 1'b0;
                end
                if (is_ref) begin
                    glob_cnt_q <= CW'(ddr_bank_pkg::REFRESH_CYCLE_TIME_CYC);
                end
                if (is_mrs) begin
                    glob_cnt_q <= CW'(ddr_bank_pkg::MODE_SET_DELAY_CYC);
                end
            end
        end
    end

    // Command pins, registered; idle cycles send no-operation
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            cmd_q  <= 4'(ddr_bank_pkg::CMD_NOP);
            bank_q <= 2'h0;
            addr_q <= '0;
        end else begin
            cmd_q  <= take ? i_cmd : 4'(ddr_bank_pkg::CMD_NOP);
            bank_q <= i_bank;
            addr_q <= i_addr;
        end
    end

    assign link.cke   = cke_q;
    assign link.cs_n  = cmd_q[3];
    assign link.ras_n = cmd_q[2];
    assign link.cas_n = cmd_q[1];
    assign link.we_n  = cmd_q[0];
    assign link.bank  = bank_q;
    assign link.addr  = addr_q;
endmodule : ddr_bank_ctrl

/* File: ddr_bank_link_sva.sv */
// Checker of the command discipline seen on the link
`timescale 1ns/1ps
module ddr_bank_link_sva (
    input wire logic        i_mclk,
    input wire logic        i_rst,
    input wire logic        cke,
    input wire logic        cs_n,
    input wire logic        ras_n,
    input wire logic        cas_n,
    input wire logic        we_n,
    input wire logic [1:0]  bank,
    input wire logic [12:0] addr
);
    logic [3:0] open_q;
    logic [3:0] open_d;
    // Decode; a deselect is quiet whatever the strobes say
    wire [3:0] cmd    = {cs_n, ras_n, cas_n, we_n};
    wire       quiet  = cs_n | (cmd == ddr_bank_pkg::CMD_NOP);
    wire       is_act = cmd == ddr_bank_pkg::CMD_ACTIVATE;
    wire       is_rd  = cmd == ddr_bank_pkg::CMD_READ;
    wire       is_wr  = cmd == ddr_bank_pkg::CMD_WRITE;
    wire       is_pre = cmd == ddr_bank_pkg::CMD_PRECHARGE;
    wire       is_ref = cmd == ddr_bank_pkg::CMD_REFRESH;
    wire       is_mrs = cmd == ddr_bank_pkg::CMD_MODE_SET;
    wire       ap     = addr[10];
    wire [3:0] sel    = 4'h1 << bank;
    wire       hit    = (open_q & sel) != 4'h0;
    // Open rows; auto precharge closes at once, which only weakens checks
    always_comb begin
        open_d = open_q;
        if (is_act)
            open_d = open_q | sel;
        if (is_pre | ((is_rd | is_wr) & ap))
            open_d = (is_pre & ap) ? 4'h0 : open_q & ~sel;
    end
    always_ff @(posedge i_mclk) begin
        if (i_rst)
            open_q <= 4'h0;
        else
            open_q <= open_d;
    end
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    // Cycles after an auto precharge access that must stay clear
    sequence s_no_rd3; !is_rd [*3]; endsequence
    sequence s_no_wr4; !is_wr [*4]; endsequence
    a_cke_two_edges: assert property (!quiet |-> cke && $past(cke))
        else $error("command sent without clock enable on two edges");
    a_refresh_all_idle: assert property (is_ref |-> !(|open_q))
        else $error("refresh sent with a row open");
    a_modeset_all_idle: assert property (is_mrs |-> !(|open_q))
        else $error("mode set sent with a row open");
    a_column_open_row: assert property ((is_rd | is_wr) |-> hit)
        else $error("column access to a bank with no open row");
    a_act_closed_bank: assert property (is_act |-> !hit)
        else $error("activate sent to a bank with an open row");
    a_refresh_quiet: assert property (is_ref |=> quiet)
        else $error("command sent during refresh");
    a_wap_read_gap: assert property (is_wr && ap |=> s_no_rd3)
        else $error("read too soon after write with auto precharge");
    a_rap_write_gap: assert property (is_rd && ap |=> s_no_wr4)
        else $error("write too soon after read with auto precharge");
endmodule : ddr_bank_link_sva

/* File: ddr_bank_command_legality_tb.sv */
// Bench: user requests into the controller, device states observed
`timescale 1ns/1ps
module ddr_bank_command_legality_tb;
    logic        i_mclk, i_rst, i_req, o_ack;
    logic        o_all_idle, o_busy, o_cmd_error;
    logic [3:0]  i_cmd;
    logic [1:0]  i_bank;
    logic [12:0] i_addr;
    logic [11:0] o_bank_state;
    int          mismatches, tests_run;
    ddr_cmd_if link ();
    ddr_bank_ctrl ddr_bank_ctrl_inst (.i_mclk(i_mclk), .i_rst(i_rst),
        .link(link), .i_req(i_req), .i_cmd(i_cmd), .i_bank(i_bank),
        .i_addr(i_addr), .o_ack(o_ack));
    ddr_bank_device ddr_bank_device_inst (.i_mclk(i_mclk), .i_rst(i_rst),
        .link(link), .o_bank_state(o_bank_state), .o_all_idle(o_all_idle),
        .o_busy(o_busy), .o_cmd_error(o_cmd_error));
    ddr_bank_link_sva ddr_bank_link_sva_inst (.i_mclk(i_mclk),
        .i_rst(i_rst), .cke(link.cke), .cs_n(link.cs_n),
        .ras_n(link.ras_n), .cas_n(link.cas_n), .we_n(link.we_n),
        .bank(link.bank), .addr(link.addr));
    initial begin
        i_mclk = 1'b0;
        forever #25 i_mclk = ~i_mclk;
    end
    task automatic check(input string what, input logic [11:0] seen,
                         input logic [11:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : conclude
    // Request held until taken; a refused one is held the whole wait
    task automatic issue(input logic [3:0] c, input logic [1:0] b,
                         input logic e = 1'b1, input logic [12:0] a = 13'h0);
        logic got;
        got = 1'b0;
        @(negedge i_mclk);
        i_req = 1'b1;
        i_cmd = c;
        i_bank = b;
        i_addr = a;
        for (int n = 0; n < 12 && got === 1'b0; n++) begin
            @(posedge i_mclk);
            #1 got = o_ack;
        end
        @(negedge i_mclk);
        i_req = 1'b0;
        check("ack", {11'h0, got}, {11'h0, e});
    endtask : issue
    // Polls because the state lags the link by the synchroniser
    task automatic bank_is(input int b, input logic [2:0] st);
        for (int n = 0; n < 10 && o_bank_state[3*b+:3] !== st; n++)
            @(negedge i_mclk);
        check("bank state", {9'h0, o_bank_state[3*b+:3]}, {9'h0, st});
    endtask : bank_is
    // Only legal traffic reaches the link, so no error is ever flagged
    always @(negedge i_mclk)
        if (i_rst === 1'b0)
            check("error flag", {11'h0, o_cmd_error}, 12'h000);
    // Some 21 requests of at most 14 cycles; far more is a hang
    initial begin
        #300000;
        mismatches++;
        conclude();
    end
    initial begin
        mismatches = 0;
        tests_run = 0;
        i_rst = 1'b1;
        i_req = 1'b0;
        i_cmd = ddr_bank_pkg::CMD_NOP;
        i_bank = 2'h0;
        i_addr = 13'h0000;
        repeat (3) @(posedge i_mclk);
        @(negedge i_mclk);
        i_rst = 1'b0;
        @(negedge i_mclk);
        check("idle flags", {10'h0, o_all_idle, o_busy}, 12'h002);
        check("bank states", o_bank_state, 12'h000);
        $display("test reset ended");
        issue(ddr_bank_pkg::CMD_ACTIVATE, 2'h0);
        bank_is(0, ddr_bank_pkg::BK_ACTIVE);
        issue(ddr_bank_pkg::CMD_ACTIVATE, 2'h0, 1'b0);
        issue(ddr_bank_pkg::CMD_READ, 2'h0);
        issue(ddr_bank_pkg::CMD_BURST_END, 2'h0);
        bank_is(0, ddr_bank_pkg::BK_READ);
        bank_is(0, ddr_bank_pkg::BK_ACTIVE);
        issue(ddr_bank_pkg::CMD_BURST_END, 2'h0, 1'b0);
        issue(ddr_bank_pkg::CMD_WRITE, 2'h0);
        bank_is(0, ddr_bank_pkg::BK_WRITE);
        issue(ddr_bank_pkg::CMD_PRECHARGE, 2'h0);
        bank_is(0, ddr_bank_pkg::BK_IDLE);
        $display("test single bank ended");
        issue(ddr_bank_pkg::CMD_ACTIVATE, 2'h0);
        issue(ddr_bank_pkg::CMD_ACTIVATE, 2'h1);
        issue(ddr_bank_pkg::CMD_REFRESH, 2'h0, 1'b0);
        issue(ddr_bank_pkg::CMD_PRECHARGE, 2'h2, 1'b1, 13'h0400);
        bank_is(1, ddr_bank_pkg::BK_IDLE);
        bank_is(0, ddr_bank_pkg::BK_IDLE);
        issue(ddr_bank_pkg::CMD_REFRESH, 2'h0);
        repeat (4) @(negedge i_mclk);
        check("lockout", {10'h0, o_all_idle, o_busy}, 12'h001);
        issue(ddr_bank_pkg::CMD_MODE_SET, 2'h0);
        $display("test all banks ended");
        issue(ddr_bank_pkg::CMD_ACTIVATE, 2'h1);
        issue(ddr_bank_pkg::CMD_ACTIVATE, 2'h3);
        issue(ddr_bank_pkg::CMD_READ, 2'h3, 1'b1, 13'h0400);
        issue(ddr_bank_pkg::CMD_WRITE, 2'h1);
        bank_is(3, ddr_bank_pkg::BK_IDLE);
        issue(ddr_bank_pkg::CMD_ACTIVATE, 2'h3);
        issue(ddr_bank_pkg::CMD_WRITE, 2'h1, 1'b1, 13'h0400);
        issue(ddr_bank_pkg::CMD_READ, 2'h3);
        bank_is(1, ddr_bank_pkg::BK_IDLE);
        issue(ddr_bank_pkg::CMD_PRECHARGE, 2'h3);
        bank_is(3, ddr_bank_pkg::BK_IDLE);
        repeat (2) @(negedge i_mclk);
        check("all idle", {11'h0, o_all_idle}, 12'h001);
        $display("test concurrent auto precharge ended");
        conclude();
    end
endmodule : ddr_bank_command_legality_tb
